// >>> stre_regs.sv
`timescale 1ns/10ps
// Summary of operation
// (RULE1) prescaler divides oscillator by 1000, ticks
// (RULE2) tick counter eight bits, wraps, resets zero
// (RULE3) all status registers read-only, both interfaces
// (RULE4) summary bit7 ORs the DSP faults
// (RULE5) summary bit5 mirrors link fault flag
// (RULE6) summary bit4 ORs memory and temperature faults
// (RULE7) summary bit3 ORs supply faults
// (RULE8) summary bit2 shows test mode state
// (RULE9) reset flag set by reset, read clears
// (RULE10) init flag clears at first data valid
// (RULE11) supply bit7 flags undervoltage
// (RULE12) supply bit3 flags analog regulator fault
// (RULE13) supply bit2 flags digital regulator fault
// (RULE14) supply bit1 flags memory regulator fault
// (RULE15) supply bit0 flags edge seal break
// (RULE16) one recovery timer reloads on any fault
// (RULE17) clearing depends on report disable setting
// (RULE18) host ignores supply flags during reset
// (RULE19) link mismatch flag, cleared by read
// (RULE20) memory flags clear on read; write-active live
// (RULE21) supply bits clear after expiry and read
module stre_regs #(
    parameter int RECOVERY_CYCLES = stre_pkg::RECOVERY_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    // host read port, shared by both serial interfaces
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // status field sent in a data transmission
    input wire logic tx_status_sent,
    input wire logic tx_spi,
    // block-level inputs from the device
    input wire logic selftest_unfinished,
    input wire logic common_mode_fault,
    input wire logic selftest_fault,
    input wire logic link_mismatch,
    input wire logic factory_mem_fault,
    input wire logic user_mem_fault,
    input wire logic user_reg_check_fault,
    input wire logic user_mem_write_active,
    input wire logic temperature_range_fault,
    input wire logic test_mode_enter,
    input wire logic test_mode_exit,
    input wire logic data_valid,
    input wire logic power_fault_report_disable,
    // analog monitor pins, asynchronous
    input wire logic supply_low_fault,
    input wire logic analog_regulator_fault,
    input wire logic digital_regulator_fault,
    input wire logic nvm_regulator_fault,
    input wire logic edge_seal_fault,
    output logic [7:0] summary_status,
    output logic [7:0] supply_status
);
    // ****************************************
    // synchronised supply monitors
    // ****************************************
    logic [4:0] mon; // {low, analog, digital, nvm, seal}
    logic [7:0] tick;
    stre_sync #(.WIDTH(5)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({supply_low_fault, analog_regulator_fault, digital_regulator_fault,
                   nvm_regulator_fault, edge_seal_fault}),
        .sync_out(mon)
    );
    stre_tick u_tick (
        .clk(clk),
        .nrst(nrst),
        .tick(tick)
    );

    // ****************************************
    // decode
    // ****************************************
    wire rd_sum = rd_strobe && (rd_addr == stre_pkg::OFS_SUMMARY);
    wire rd_sup = rd_strobe && (rd_addr == stre_pkg::OFS_SUPPLY);
    wire rd_tick = rd_strobe && (rd_addr == stre_pkg::OFS_TICK);
    wire any_mon = |mon;
    // transmission clears flags it carried
    wire tx_clear = tx_status_sent;

    // sticky flags
    logic reset_occurred_flag;
    logic init_pending_flag;
    logic test_state_flag;
    logic link_fault;
    logic [3:0] memtemp_sticky; // {factory, user, regcheck, temperature}
    logic [4:0] supply_sticky;
    logic [$clog2(RECOVERY_CYCLES+1)-1:0] rcv_cnt;

    // ****************************************
    // reset and init flags
    // ****************************************
    // (RULE9) set by reset, read or transmission clears
    wire next_reset_flag = reset_occurred_flag && !(rd_sum || tx_clear);
    // (RULE10) clears when data first valid
    wire next_init_flag = init_pending_flag && !data_valid;
    // (RULE8) only test mode operation changes it
    wire next_test_flag = test_mode_enter ? 1'b1 : (test_mode_exit ? 1'b0 : test_state_flag);

    // reset and init flags set on reset, test flag cleared; reset is asynchronous
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_occurred_flag <= 1'b1;
            init_pending_flag <= 1'b1;
            test_state_flag <= 1'b0;
        end else begin
            reset_occurred_flag <= next_reset_flag;
            init_pending_flag <= next_init_flag;
            test_state_flag <= next_test_flag;
        end
    end

    // ****************************************
    // link and memory flags
    // ****************************************
    // (RULE19) set wins over read clear
    wire link_clr = (rd_strobe && (rd_addr == stre_pkg::OFS_LINK)) || (tx_clear && tx_spi);
    wire next_link = link_mismatch || (link_fault && !link_clr);
    // (RULE20) memory register read or transmission clears
    wire mem_clr = (rd_strobe && (rd_addr == stre_pkg::OFS_MEMTEMP)) || tx_clear;
    wire [3:0] mem_set = {factory_mem_fault, user_mem_fault, user_reg_check_fault,
                          temperature_range_fault};
    wire [3:0] next_memtemp = mem_set | (memtemp_sticky & {4{!mem_clr}});

    // sticky link and memory faults
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link_fault <= 1'b0;
            memtemp_sticky <= 4'h0;
        end else begin
            link_fault <= next_link;
            memtemp_sticky <= next_memtemp;
        end
    end

    // ****************************************
    // supply recovery timer
    // ****************************************
    wire rcv_done = (rcv_cnt == '0);
    // (RULE16) reload while any fault present
    wire [$bits(rcv_cnt)-1:0] next_rcv = any_mon ? $bits(rcv_cnt)'(RECOVERY_CYCLES) :
                                         (rcv_done ? rcv_cnt : rcv_cnt - 1'b1);

    // shared countdown for every supply bit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rcv_cnt <= '0;
        end else begin
            rcv_cnt <= next_rcv;
        end
    end

    // (RULE21) read after expiry unlocks the clear
    wire sup_clear_ok = rd_sup && rcv_done && !any_mon;
    // (RULE17) disabled reporting follows monitor live
    wire [4:0] next_supply = power_fault_report_disable ? mon :
                             (mon | (supply_sticky & {5{!sup_clear_ok}}));

    // (RULE11) (RULE12) (RULE13) (RULE14) (RULE15) latch monitors
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            supply_sticky <= 5'h00;
        end else begin
            supply_sticky <= next_supply;
        end
    end

    // ****************************************
    // register images
    // ****************************************
    wire [7:0] next_supply_img = {supply_sticky[4], 3'b000, supply_sticky[3:0]};
    wire dsp_any = selftest_unfinished | common_mode_fault | selftest_fault;
    wire mem_any = (|memtemp_sticky) | user_mem_write_active;
    wire [7:0] next_summary_img = {
        dsp_any,                 // (RULE4) DSP OR
        1'b0,
        link_fault,              // (RULE5) link fault
        mem_any,                 // (RULE6) memory OR
        |supply_sticky,          // (RULE7) supply OR
        test_state_flag,
        reset_occurred_flag,
        init_pending_flag
    };
    // (RULE3) read-only mux, unmapped reads zero
    wire [7:0] next_rd_data = rd_tick ? tick :
                              rd_sum ? next_summary_img :
                              rd_sup ? next_supply_img : 8'h00;

    // registered outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            summary_status <= 8'h00;
            supply_status <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
            rd_valid <= rd_strobe;
            summary_status <= next_summary_img;
            supply_status <= next_supply_img;
        end
    end
endmodule

// >>> stre_pkg.sv
package stre_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_TICK = 8'h00;
    localparam logic [7:0] OFS_SUMMARY = 8'h01;
    localparam logic [7:0] OFS_SUPPLY = 8'h02;
    // outside this bank; a read here only clears the flags they hold
    localparam logic [7:0] OFS_MEMTEMP = 8'h03;
    localparam logic [7:0] OFS_LINK = 8'h04;
    // ****************************************
    // summary_status field positions
    // ****************************************
    localparam int SUM_DSP = 7;
    localparam int SUM_LINK = 5;
    localparam int SUM_MEMTEMP = 4;
    localparam int SUM_SUPPLY = 3;
    localparam int SUM_TEST = 2;
    localparam int SUM_RESET = 1;
    localparam int SUM_INIT = 0;
    // ****************************************
    // supply_status field positions
    // ****************************************
    localparam int SUP_LOW = 7;
    localparam int SUP_ANALOG = 3;
    localparam int SUP_DIGITAL = 2;
    localparam int SUP_NVM = 1;
    localparam int SUP_SEAL = 0;
    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [7:0] TICK_RESET = 8'h00;
    localparam int PRESCALE_DIV = 1000;
    localparam int TICK_PERIOD_US = 100;
    localparam int CLK_MHZ = 125;
    // clock cycles per tick, the prescaler output is one per this many clocks
    localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;
    // supply recovery interval in microseconds, plain default
    localparam int RECOVERY_US = 1000;
    localparam int RECOVERY_CYCLES = RECOVERY_US * CLK_MHZ;
endpackage

// >>> stre_sync.sv
`timescale 1ns/10ps
// ****************************************
// three-stage synchroniser with agreement filter
// ****************************************
module stre_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1; // read only by stage2
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
    wire [WIDTH-1:0] next_sync_out = (agree & stage3) | (~agree & sync_out);

    // shift chain, output changes only once the last two stages agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= next_sync_out;
        end
    end
endmodule

// >>> stre_tick.sv
`timescale 1ns/10ps
// ****************************************
// prescaler and rolling tick counter
// ****************************************
module stre_tick #(
    parameter int DIV = stre_pkg::PRESCALE_DIV,
    parameter int CYCLES = stre_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    output logic [7:0] tick
);
    // oscillator edges come from a phase accumulator: DIV pulses per CYCLES clocks,
    // so the tick period is exact even though one pulse is not a whole clock count
    logic [13:0] osc_acc;
    logic [9:0] pre_cnt; // 10-bit prescaler
    wire [14:0] acc_sum = {1'b0, osc_acc} + 15'(DIV);
    wire osc_pulse = (acc_sum >= 15'(CYCLES));
    wire [14:0] acc_wrap = acc_sum - 15'(CYCLES);
    wire [13:0] next_acc = osc_pulse ? acc_wrap[13:0] : acc_sum[13:0];
    wire pre_wrap = osc_pulse && (pre_cnt == 10'(DIV - 1));

    // oscillator phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_acc <= 14'h0000;
        end else begin
            osc_acc <= next_acc;
        end
    end

    // (RULE1) divide by thousand
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_cnt <= 10'h000;
        end else if (osc_pulse) begin
            pre_cnt <= pre_wrap ? 10'h000 : pre_cnt + 10'h001;
        end
    end

    // (RULE2) free-running wrap count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick <= stre_pkg::TICK_RESET;
        end else if (pre_wrap) begin
            tick <= tick + 8'h01;
        end
    end
endmodule

// >>> stre_checker.sv
`timescale 1ns/10ps
// ****************************************
// status bank checker
// ****************************************
module stre_checker #(
    parameter int RECOVERY_CYCLES = stre_pkg::RECOVERY_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic selftest_unfinished,
    input wire logic common_mode_fault,
    input wire logic selftest_fault,
    input wire logic test_mode_enter,
    input wire logic data_valid,
    input wire logic supply_low_fault,
    input wire logic [7:0] summary_status,
    input wire logic [7:0] supply_status
);
    // any dsp fault level, held three cycles to cover the output register, the only stage in its path
    wire logic dsp_any = selftest_unfinished | common_mode_fault | selftest_fault;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_read_answer: assert property (rd_strobe |=> rd_valid)
        else $error("read not answered");
    a_idle_zero: assert property (!rd_strobe |=> !rd_valid && rd_data == 8'h00)
        else $error("read data without request");
    a_unmapped_zero: assert property (rd_strobe && rd_addr > 8'h02 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_dsp_set: assert property (dsp_any [*3] |=> summary_status[7])
        else $error("dsp summary not set");
    a_dsp_clear: assert property (!dsp_any [*3] |=> !summary_status[7])
        else $error("dsp summary not clear");
    a_test_enter: assert property (test_mode_enter |-> ##[1:3] summary_status[2])
        else $error("test flag not set");
    a_init_clear: assert property (data_valid |-> ##[1:3] !summary_status[0])
        else $error("init flag not cleared");
    a_supply_low: assert property (supply_low_fault [*6] |=> supply_status[7])
        else $error("undervoltage not flagged");
    a_supply_sum: assert property (supply_status != 8'h00 |-> ##[0:2] summary_status[3])
        else $error("supply summary not set");
endmodule

// >>> stre_host.sv
`timescale 1ns/10ps
// ****************************************
// host reader on the status read port
// ****************************************
module stre_host (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [7:0] addr,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic rd_strobe,
    output logic [7:0] rd_addr,
    output logic [7:0] data,
    output logic done
);
    // one strobe per request; idle address flips so a stale value is never mistaken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_strobe <= 1'b0;
            rd_addr <= 8'h00;
        end else begin
            rd_strobe <= go;
            rd_addr <= go ? addr : ~rd_addr;
        end
    end
    // ignore reset data
    // nothing is taken while reset is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
            data <= 8'h00;
        end else begin
            done <= rd_valid;
            data <= rd_valid ? rd_data : data;
        end
    end
endmodule

// >>> stre_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [19:0] iv = 20'h0_0000; // block inputs by bit
    logic go = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd_strobe, rd_valid, done;
    logic [7:0] rd_addr, rd_data, data, summary_status, supply_status;
    int err_count = 0;
    int check_count = 0;
    int sb;
    always #4 clk = ~clk;
    stre_regs #(.RECOVERY_CYCLES(20)) u_dut (
        .clk(clk), .nrst(nrst), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .tx_status_sent(iv[18]), .tx_spi(iv[19]),
        .selftest_unfinished(iv[0]), .common_mode_fault(iv[1]), .selftest_fault(iv[2]),
        .link_mismatch(iv[3]), .factory_mem_fault(iv[4]), .user_mem_fault(iv[5]),
        .user_reg_check_fault(iv[6]), .user_mem_write_active(iv[7]),
        .temperature_range_fault(iv[8]), .test_mode_enter(iv[9]), .test_mode_exit(iv[10]),
        .data_valid(iv[11]), .power_fault_report_disable(iv[12]),
        .supply_low_fault(iv[13]), .analog_regulator_fault(iv[14]),
        .digital_regulator_fault(iv[15]), .nvm_regulator_fault(iv[16]),
        .edge_seal_fault(iv[17]), .summary_status(summary_status),
        .supply_status(supply_status));
    stre_host u_host (
        .clk(clk), .nrst(nrst), .go(go), .addr(addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .data(data),
        .done(done));
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // drive one input bit, then let n edges pass
    task set(input int i, input logic v, input int n);
        iv[i] <= v;
        tick(n);
    endtask
    task rd(input logic [7:0] a);
        go <= 1'b1;
        addr <= a;
        @(posedge clk);
        go <= 1'b0;
        for (int k = 0; k < 8 && done !== 1'b1; k++) @(posedge clk);
        `CHK(done, 1'b1)
    endtask
    task do_reset();
        nrst <= 1'b0;
        tick(3);
        nrst <= 1'b1;
        tick(1);
    endtask
    task finish_test();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        do_reset();
        rd(8'h01);
        `CHK(data, 8'h03)
        rd(8'h01);
        `CHK(data, 8'h01)
        rd(8'h05);
        `CHK(data, 8'h00)
        // one count per 12500 clocks (100 us), sampled either side of each step
        for (int k = 0; k < 2; k++) begin
            tick(12400);
            rd(8'h00);
            `CHK(data, k[7:0])
            tick(100);
            rd(8'h00);
            `CHK(data, k[7:0] + 8'h01)
        end
        set(11, 1'b1, 1);
        set(11, 1'b0, 4);
        `CHK(summary_status, 8'h00)
        // summary sources: live dsp and write-active, sticky link and memory
        for (int i = 0; i < 9; i++) begin
            sb = (i < 3) ? 7 : (i == 3) ? 5 : 4;
            set(i, 1'b1, 4);
            `CHK(summary_status[sb], 1'b1)
            set(i, 1'b0, 4);
            `CHK(summary_status[sb], (i > 2 && i != 7))
            rd(i == 3 ? 8'h04 : 8'h03);
            tick(3);
            `CHK(summary_status[sb], 1'b0)
        end
        set(9, 1'b1, 1);
        set(9, 1'b0, 4);
        rd(8'h01);
        `CHK(data, 8'h04)
        set(10, 1'b1, 1);
        set(10, 1'b0, 4);
        `CHK(summary_status, 8'h00)
        // each monitor stays latched until timer expiry and a read
        for (int i = 0; i < 5; i++) begin
            sb = (i == 0) ? 7 : 4 - i;
            set(13 + i, 1'b1, 8);
            rd(8'h02);
            `CHK(data, 8'h01 << sb)
            `CHK(summary_status[3], 1'b1)
            set(13 + i, 1'b0, 8);
            rd(8'h02);
            `CHK(data, 8'h01 << sb)
            tick(30);
            rd(8'h02);
            rd(8'h02);
            `CHK(data, 8'h00)
        end
        set(12, 1'b1, 1);
        set(13, 1'b1, 8);
        `CHK(supply_status, 8'h80)
        set(13, 1'b0, 8);
        `CHK(supply_status, 8'h00)
        set(12, 1'b0, 1);
        // second reset, then a status transmission on spi clears both flags
        do_reset();
        set(3, 1'b1, 1);
        set(3, 1'b0, 1);
        iv[19] <= 1'b1;
        set(18, 1'b1, 1);
        set(18, 1'b0, 4);
        `CHK(summary_status, 8'h01)
        finish_test();
    end
    // hang guard, about twice the expected run
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule
bind stre_regs stre_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk (
    .clk, .nrst, .rd_strobe, .rd_addr, .rd_data, .rd_valid, .selftest_unfinished,
    .common_mode_fault, .selftest_fault, .test_mode_enter, .data_valid,
    .supply_low_fault, .summary_status, .supply_status);
